// File: ddc_gain_switch_and_nco_tuning.sv
// DDC front end: gain switch detectors, input scaling buffer and NCO tuning hold-off
`timescale 1ns/10ps
`default_nettype none
`include "ddc_gain_nco_defines.svh"

module ddc_gain_switch_and_nco_tuning #(
  parameter int NCH = 4,
  parameter int DW = 12,
  parameter int DLY = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic signed [DW-1:0] adc_a,
  input wire logic signed [DW-1:0] adc_b,
  input wire logic in_valid,
  output logic in_ready,
  output logic [NCH*DW-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic gain_switch_indicator_port_a,
  output logic gain_switch_indicator_port_b,
  input wire logic [3:0] sync_pin,
  input wire logic [NCH-1:0] chan_sleep,
  input wire logic [1:0] reg_chan,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [19:0] reg_wdata,
  output logic [19:0] reg_rdata,
  output logic [NCH*16-1:0] nco_phase,
  input wire logic [11:0] resampling_comb_filter_decim,
  input wire logic [5:0] fifth_order_comb_filter_decim,
  input wire logic [7:0] rcf_taps,
  output logic [23:0] latency
);

  // Magnitude of a signed sample; the most negative code still fits unsigned
  function automatic logic [DW-1:0] mag_f(input logic signed [DW-1:0] s);
    mag_f = s[DW-1] ? DW'(-s) : DW'(s);
  endfunction : mag_f

  logic [DW-1:0] upper_q [2], upper_d [2], lower_q [2], lower_d [2];
  logic [15:0] dwell_q [2], dwell_d [2], dcnt_q [2], dcnt_d [2];
  logic [3:0] swdly_q [2], swdly_d [2];
  logic [DLY-1:0] hist_q [2], hist_d [2];
  logic [1:0] ind_q, ind_d, run_q, run_d, dind;
  logic [DW-1:0] mag [2];
  logic in_fire;

  ddc_gain_nco_pkg::hold_t hold_q [NCH], hold_d [NCH], hcnt_q [NCH], hcnt_d [NCH];
  ddc_gain_nco_pkg::tune_t shadow_q [NCH], shadow_d [NCH], active_q [NCH], active_d [NCH];
  ddc_gain_nco_pkg::tune_t phase_q [NCH], phase_d [NCH];
  ddc_gain_nco_pkg::ctrl_t ctrl_q [NCH], ctrl_d [NCH];
  ddc_gain_nco_pkg::scale_pair_t scale_q [NCH], scale_d [NCH];
  logic [NCH-1:0] hrun_q, hrun_d, slp_q, evt;
  logic [3:0] sync_prev_q;
  ddc_gain_nco_pkg::rdata_t rdata_d;

  logic [NCH*DW-1:0] mem_q [2], mem_d [2], push_word;
  logic [1:0] cnt_q, cnt_d;
  logic in_ready_d, out_valid_d;
  logic [23:0] lat_d;

  assign in_fire = in_valid & in_ready;
  assign mag[0] = mag_f(adc_a);
  assign mag[1] = mag_f(adc_b);

  // Delayed indicator seen by the scaler; a delay of zero uses the live flag
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      dind[p] = (swdly_q[p] == 4'h0) ? ind_q[p] : hist_q[p][swdly_q[p] - 4'h1];
    end
  end

  // Threshold detector with dwell hysteresis, one per input port
  always_comb begin
    ind_d = ind_q;
    run_d = run_q;
    dcnt_d = dcnt_q;
    for (int p = 0; p < 2; p++) begin
      hist_d[p] = {hist_q[p][DLY-2:0], ind_q[p]};
      if (in_fire && mag[p] >= upper_q[p]) begin
        ind_d[p] = 1'b1;
        run_d[p] = 1'b0;
      end else if (ind_q[p] && run_q[p] && dcnt_q[p] == 16'h0000) begin
        ind_d[p] = 1'b0;
        run_d[p] = 1'b0;
      end else if (ind_q[p] && in_fire && mag[p] >= lower_q[p]) begin
        run_d[p] = 1'b0;
      end else if (ind_q[p] && !run_q[p] && in_fire) begin
        run_d[p] = 1'b1;
        dcnt_d[p] = dwell_q[p];
      end else if (run_q[p]) begin
        dcnt_d[p] = dcnt_q[p] - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ind_q <= 2'b00;
      run_q <= 2'b00;
      for (int p = 0; p < 2; p++) begin
        dcnt_q[p] <= 16'h0000;
        hist_q[p] <= '0;
      end
    end else begin
      ind_q <= ind_d;
      run_q <= run_d;
      dcnt_q <= dcnt_d;
      hist_q <= hist_d;
    end
  end

  assign gain_switch_indicator_port_a = ind_q[0];
  assign gain_switch_indicator_port_b = ind_q[1];

  // Hop and sleep-exit events; sync pins are taken as synchronous, so edges are safe here
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      logic [1:0] sel;
      sel = ctrl_q[c][`CTRL_SYNC_LSB +: 2];
      evt[c] = (sync_pin[sel] & ~sync_prev_q[sel]) | (slp_q[c] & ~chan_sleep[c]);
    end
  end

  // Register port, hold-off counters and phase accumulators
  always_comb begin
    upper_d = upper_q;
    lower_d = lower_q;
    dwell_d = dwell_q;
    swdly_d = swdly_q;
    hold_d = hold_q;
    shadow_d = shadow_q;
    active_d = active_q;
    ctrl_d = ctrl_q;
    scale_d = scale_q;
    hcnt_d = hcnt_q;
    hrun_d = hrun_q;
    rdata_d = 20'h00000;
    for (int c = 0; c < NCH; c++) begin
      phase_d[c] = phase_q[c] + active_q[c];
      if (evt[c] && hold_q[c] != 16'h0000) begin
        hcnt_d[c] = hold_q[c];
        hrun_d[c] = 1'b1;
      end else if (hrun_q[c] && hcnt_q[c] == 16'h0001) begin
        active_d[c] = shadow_q[c];
        hrun_d[c] = 1'b0;
      end else if (hrun_q[c]) begin
        hcnt_d[c] = hcnt_q[c] - 16'h0001;
      end
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `ADDR_HOLDOFF: hold_d[reg_chan] = reg_wdata[15:0];
        `ADDR_TUNE_LO: shadow_d[reg_chan][15:0] = reg_wdata[15:0];
        `ADDR_TUNE_HI: shadow_d[reg_chan][31:16] = reg_wdata[15:0];
        `ADDR_NCO_CTRL: ctrl_d[reg_chan] = reg_wdata[8:0];
        `ADDR_SCALE: scale_d[reg_chan] = reg_wdata[9:0];
        `ADDR_UPPER: upper_d[reg_chan[0]] = reg_wdata[DW-1:0];
        `ADDR_LOWER: lower_d[reg_chan[0]] = reg_wdata[DW-1:0];
        `ADDR_DWELL: dwell_d[reg_chan[0]] = reg_wdata[15:0];
        `ADDR_SWDLY: swdly_d[reg_chan[0]] = reg_wdata[3:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `ADDR_HOLDOFF: rdata_d = {4'h0, hold_q[reg_chan]};
        `ADDR_TUNE_LO: rdata_d = {4'h0, active_q[reg_chan][15:0]};
        `ADDR_TUNE_HI: rdata_d = {4'h0, active_q[reg_chan][31:16]};
        `ADDR_NCO_CTRL: rdata_d = {11'h000, ctrl_q[reg_chan]};
        `ADDR_SCALE: rdata_d = {10'h000, scale_q[reg_chan]};
        `ADDR_UPPER: rdata_d = 20'(upper_q[reg_chan[0]]);
        `ADDR_LOWER: rdata_d = 20'(lower_q[reg_chan[0]]);
        `ADDR_DWELL: rdata_d = {4'h0, dwell_q[reg_chan[0]]};
        `ADDR_SWDLY: rdata_d = {16'h0000, swdly_q[reg_chan[0]]};
        default: rdata_d = 20'h00000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int p = 0; p < 2; p++) begin
        upper_q[p] <= `UPPER_RST;
        lower_q[p] <= `LOWER_RST;
        dwell_q[p] <= `DWELL_RST;
        swdly_q[p] <= `SWDLY_RST;
      end
      for (int c = 0; c < NCH; c++) begin
        hold_q[c] <= `HOLDOFF_RST;
        shadow_q[c] <= 32'h00000000;
        active_q[c] <= 32'h00000000;
        phase_q[c] <= 32'h00000000;
        ctrl_q[c] <= `CTRL_RST;
        scale_q[c] <= `SCALE_RST;
        hcnt_q[c] <= 16'h0000;
      end
      hrun_q <= '0;
      slp_q <= '1;
      sync_prev_q <= 4'hF;
      reg_rdata <= 20'h00000;
    end else begin
      upper_q <= upper_d;
      lower_q <= lower_d;
      dwell_q <= dwell_d;
      swdly_q <= swdly_d;
      hold_q <= hold_d;
      shadow_q <= shadow_d;
      active_q <= active_d;
      phase_q <= phase_d;
      ctrl_q <= ctrl_d;
      scale_q <= scale_d;
      hcnt_q <= hcnt_d;
      hrun_q <= hrun_d;
      slp_q <= chan_sleep;
      sync_prev_q <= sync_pin;
      reg_rdata <= rdata_d;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_phase
    assign nco_phase[c*16 +: 16] = phase_q[c][31:16];
  end

  // Scale each channel's sample by its port's delayed gain state before the resampler
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      logic ps;
      ddc_gain_nco_pkg::scale_t sc;
      logic signed [DW-1:0] s;
      ps = ctrl_q[c][`CTRL_INSEL_BIT];
      s = ps ? adc_b : adc_a;
      sc = dind[ps] ? scale_q[c][`SCALE_LOUD_LSB +: 5] : scale_q[c][`SCALE_QUIET_LSB +: 5];
      push_word[c*DW +: DW] = s >>> sc;
    end
  end

  // Two-entry buffer: a stall downstream fills it and then drops in_ready
  always_comb begin
    logic [1:0] wi;
    logic pop;
    pop = out_valid & out_ready;
    mem_d = mem_q;
    cnt_d = cnt_q;
    if (pop) begin
      mem_d[0] = mem_q[1];
      cnt_d = cnt_q - 2'd1;
    end
    wi = cnt_d;
    if (in_fire) begin
      mem_d[wi[0]] = push_word;
      cnt_d = cnt_d + 2'd1;
    end
    in_ready_d = cnt_d != 2'd2;
    out_valid_d = cnt_d != 2'd0;
    lat_d = 24'(32'(resampling_comb_filter_decim) * (32'(fifth_order_comb_filter_decim) + `LAT_FIFTH_ORDER_COMB_FILTER_ADD) + 32'(rcf_taps) + `LAT_FIXED_ADD);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q <= 2'd0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      latency <= 24'h000000;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      in_ready <= in_ready_d;
      out_valid <= out_valid_d;
      latency <= lat_d;
    end
  end

  assign out_data = mem_q[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_hold_one;
    hrun_q[0] && hcnt_q[0] == 16'h0001;
  endsequence
  property p_ind_up;
    in_fire && mag[0] >= upper_q[0] |=> ind_q[0];
  endproperty
  a_ind_up: assert property (p_ind_up) else $error("indicator A missed upper threshold");
  property p_ind_fall;
    $fell(ind_q[0]) |-> $past(run_q[0]) && $past(dcnt_q[0]) == 16'h0000;
  endproperty
  a_ind_fall: assert property (p_ind_fall) else $error("indicator A fell before dwell end");
  property p_dwell_reset;
    run_q[0] && ind_q[0] && in_fire && mag[0] >= lower_q[0] && dcnt_q[0] != 16'h0000 |=> !run_q[0];
  endproperty
  a_dwell_reset: assert property (p_dwell_reset) else $error("dwell not reset on rise");
  property p_dwell_load;
    ind_q[1] && !run_q[1] && in_fire && mag[1] < lower_q[1] |=> run_q[1] && dcnt_q[1] == $past(dwell_q[1]);
  endproperty
  a_dwell_load: assert property (p_dwell_load) else $error("dwell B not loaded");
  property p_active_src;
    !$stable(active_q[0]) |-> $past(hrun_q[0]) && $past(hcnt_q[0]) == 16'h0001 && active_q[0] == $past(shadow_q[0]);
  endproperty
  a_active_src: assert property (p_active_src) else $error("active word changed outside hold-off");
  property p_hold_zero;
    evt[0] && hold_q[0] == 16'h0000 && !hrun_q[0] |=> !hrun_q[0];
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("zero hold-off started a count");
  property p_hold_one;
    evt[0] && hold_q[0] == 16'h0001 && !reg_wr |=> s_hold_one ##1 !hrun_q[0];
  endproperty
  a_hold_one: assert property (p_hold_one) else $error("hold-off of one not immediate");
  property p_read_active;
    reg_rd && reg_addr == `ADDR_TUNE_LO && reg_chan == 2'd0 |=> reg_rdata[15:0] == $past(active_q[0][15:0]);
  endproperty
  a_read_active: assert property (p_read_active) else $error("tuning read not active word");

endmodule : ddc_gain_switch_and_nco_tuning
`default_nettype wire

// File: ddc_gain_nco_defines.svh
// Register offsets, field positions, reset values and fixed counts of the DDC front end
`ifndef DDC_GAIN_NCO_DEFINES_SVH
`define DDC_GAIN_NCO_DEFINES_SVH
`define ADDR_HOLDOFF 8'h84
`define ADDR_TUNE_LO 8'h85
`define ADDR_TUNE_HI 8'h86
`define ADDR_NCO_CTRL 8'h88
`define ADDR_SCALE 8'h92
`define ADDR_UPPER 8'hA0
`define ADDR_LOWER 8'hA1
`define ADDR_DWELL 8'hA2
`define ADDR_SWDLY 8'hA3
`define CTRL_INSEL_BIT 6
`define CTRL_SYNC_LSB 7
`define SCALE_QUIET_LSB 5
`define SCALE_LOUD_LSB 0
`define UPPER_RST 12'hFFF
`define LOWER_RST 12'h000
`define DWELL_RST 16'h0000
`define SWDLY_RST 4'h0
`define HOLDOFF_RST 16'h0000
`define CTRL_RST 9'h000
`define SCALE_RST 10'h000
`define LAT_FIFTH_ORDER_COMB_FILTER_ADD 7
`define LAT_FIXED_ADD 26
`endif

// File: ddc_gain_nco_pkg.sv
// Shared types of the DDC gain switch and tuning block
package ddc_gain_nco_pkg;
  typedef logic [4:0] scale_t;
  typedef logic [31:0] tune_t;
  typedef logic [15:0] hold_t;
  typedef logic [7:0] addr_t;
  typedef logic [19:0] rdata_t;
  typedef logic [8:0] ctrl_t;
  typedef logic [9:0] scale_pair_t;
endpackage : ddc_gain_nco_pkg

// File: adc_src.sv
// Sample source standing in for the two converter ports
`timescale 1ns/10ps
`default_nettype none
module adc_src (
  input wire logic clk,
  input wire logic srst,
  input wire logic go,
  input wire logic [11:0] a_val,
  input wire logic [11:0] b_val,
  input wire logic in_ready,
  output logic [11:0] adc_a,
  output logic [11:0] adc_b,
  output logic in_valid
);
  // Hold a pair until taken, then invert the lines so stale data never passes as fresh
  always_ff @(posedge clk) begin
    if (srst) begin
      in_valid <= 1'b0;
      adc_a <= 12'h000;
      adc_b <= 12'h000;
    end else if (go) begin
      in_valid <= 1'b1;
      adc_a <= a_val;
      adc_b <= b_val;
    end else if (in_valid && in_ready) begin
      in_valid <= 1'b0;
      adc_a <= ~adc_a;
      adc_b <= ~adc_b;
    end
  end
endmodule : adc_src
`default_nettype wire

// File: tb_top.sv
// Self-checking bench of the DDC gain switch and tuning block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic go = 1'b0;
  logic [11:0] a_val = 12'h000;
  logic [11:0] b_val = 12'h000;
  logic [11:0] adc_a;
  logic [11:0] adc_b;
  logic in_valid;
  logic in_ready;
  logic [47:0] out_data;
  logic out_valid;
  logic out_ready = 1'b1;
  logic ind_a;
  logic ind_b;
  logic [3:0] sync_pin = 4'h0;
  logic [3:0] chan_sleep = 4'h0;
  logic [1:0] reg_chan = 2'h0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [19:0] reg_wdata = 20'h00000;
  logic [19:0] reg_rdata;
  logic [63:0] nco_phase;
  logic [23:0] latency;
  logic [11:0] last0 = 12'h000;
  logic [11:0] last1 = 12'h000;
  logic [11:0] rdec = 12'h004;
  logic [5:0] cdec = 6'h02;
  logic [7:0] taps = 8'h0A;
  int bad_count = 0;
  int num_checks = 0;

  // Master clock, 4 ns period
  always #2 clk = ~clk;

  // Filter counts are bench signals so the latency sum can be moved mid-run
  ddc_gain_switch_and_nco_tuning DUT (.clk(clk), .srst(srst), .adc_a(adc_a), .adc_b(adc_b),
    .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .gain_switch_indicator_port_a(ind_a), .gain_switch_indicator_port_b(ind_b),
    .sync_pin(sync_pin), .chan_sleep(chan_sleep), .reg_chan(reg_chan), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .nco_phase(nco_phase), .resampling_comb_filter_decim(rdec), .fifth_order_comb_filter_decim(cdec), .rcf_taps(taps),
    .latency(latency));

  adc_src SRC (.clk(clk), .srst(srst), .go(go), .a_val(a_val), .b_val(b_val),
    .in_ready(in_ready), .adc_a(adc_a), .adc_b(adc_b), .in_valid(in_valid));

  // Keep lanes 0 and 1 of the last word taken, since words pass in one cycle
  always @(posedge clk) begin
    if (out_valid && out_ready) begin
      last0 <= out_data[11:0];
      last1 <= out_data[23:12];
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Returns just after the edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [1:0] ch, input logic [7:0] a, input logic [19:0] d);
    @(posedge clk);
    reg_chan <= ch;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data is looked at in the one cycle it stands
  task automatic rd(input logic [1:0] ch, input logic [7:0] a, input logic [19:0] exp);
    @(posedge clk);
    reg_chan <= ch;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  // Offer one pair and return at the edge that takes it
  task automatic send(input logic [11:0] a, input logic [11:0] b);
    int i;
    i = 0;
    @(posedge clk);
    go <= 1'b1;
    a_val <= a;
    b_val <= b;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
      i++;
    end while (!(in_valid && in_ready) && i < 30);
    chk(24'(in_valid & in_ready), 24'h000001);
  endtask : send

  task automatic hop(input int p);
    @(posedge clk);
    sync_pin <= 4'h1 << p;
    @(posedge clk);
    sync_pin <= 4'h0;
  endtask : hop

  task automatic t_regs;
    chk(latency, 24'h000048);
    @(posedge clk);
    rdec <= 12'h010;
    cdec <= 6'h05;
    taps <= 8'hA0;
    tick(2);
    chk(latency, 24'h00017A);
    rd(2'h0, 8'h84, 20'h00000);
    rd(2'h0, 8'h10, 20'h00000);
    wr(2'h0, 8'h85, 20'h01234);
    wr(2'h0, 8'h86, 20'h0ABCD);
    rd(2'h0, 8'h85, 20'h00000);
    hop(0);
    tick(4);
    rd(2'h0, 8'h85, 20'h00000);
  endtask : t_regs

  task automatic t_hop;
    wr(2'h0, 8'h84, 20'h00001);
    hop(0);
    tick(3);
    rd(2'h0, 8'h85, 20'h01234);
    rd(2'h0, 8'h86, 20'h0ABCD);
    wr(2'h0, 8'h88, 20'h00180);
    wr(2'h0, 8'h85, 20'h05678);
    hop(0);
    tick(3);
    rd(2'h0, 8'h85, 20'h01234);
    hop(3);
    tick(3);
    rd(2'h0, 8'h85, 20'h05678);
  endtask : t_hop

  task automatic t_sleep;
    wr(2'h0, 8'h84, 20'h00006);
    wr(2'h0, 8'h85, 20'h09999);
    @(posedge clk);
    chan_sleep <= 4'h1;
    repeat (2) @(posedge clk);
    chan_sleep <= 4'h0;
    rd(2'h0, 8'h85, 20'h05678);
    tick(3);
    rd(2'h0, 8'h85, 20'h05678);
    rd(2'h0, 8'h85, 20'h09999);
    wr(2'h0, 8'h85, 20'h07777);
    hop(3);
    tick(2);
    hop(3);
    tick(2);
    rd(2'h0, 8'h85, 20'h09999);
    tick(6);
    rd(2'h0, 8'h85, 20'h07777);
  endtask : t_sleep

  // Two words fill the buffer while the sink stalls; nothing may be lost
  task automatic t_stream;
    wr(2'h0, 8'h92, 20'h00040);
    wr(2'h1, 8'h88, 20'h00040);
    @(posedge clk);
    out_ready <= 1'b0;
    send(12'h100, 12'h010);
    send(12'h300, 12'h020);
    tick(1);
    chk(in_ready, 1'b0);
    chk(out_data[11:0], 12'h040);
    chk(out_data[23:12], 12'h010);
    chk(out_valid, 1'b1);
    @(posedge clk);
    out_ready <= 1'b1;
    tick(3);
    chk(last0, 12'h0C0);
    chk(out_valid, 1'b0);
  endtask : t_stream

  task automatic t_gain;
    wr(2'h0, 8'hA0, 20'h00400);
    wr(2'h0, 8'hA1, 20'h00100);
    wr(2'h0, 8'hA2, 20'h00008);
    wr(2'h0, 8'h92, 20'h00041);
    send(12'hC00, 12'h7FF);
    tick(2);
    chk(ind_a, 1'b1);
    chk(ind_b, 1'b0);
    send(12'h600, 12'h000);
    tick(2);
    chk(last0, 12'h300);
    send(12'h050, 12'h000);
    send(12'h200, 12'h000);
    tick(20);
    chk(ind_a, 1'b1);
    send(12'h050, 12'h000);
    tick(8);
    chk(ind_a, 1'b1);
    tick(1);
    chk(ind_a, 1'b0);
  endtask : t_gain

  // Port B trips on its own thresholds; its scale switch lags by the programmed delay
  task automatic t_portb;
    wr(2'h1, 8'hA0, 20'h00400);
    wr(2'h1, 8'hA1, 20'h00100);
    wr(2'h1, 8'hA2, 20'h00002);
    wr(2'h1, 8'hA3, 20'h00003);
    wr(2'h1, 8'h92, 20'h00041);
    send(12'h000, 12'h600);
    send(12'h000, 12'h600);
    tick(1);
    chk(last1, 12'h180);
    chk(ind_b, 1'b1);
    chk(ind_a, 1'b0);
    send(12'h000, 12'h600);
    tick(1);
    chk(last1, 12'h300);
    send(12'h000, 12'h050);
    tick(2);
    chk(ind_b, 1'b1);
    tick(1);
    chk(ind_b, 1'b0);
  endtask : t_portb

  // Channel 2 tuned to one top step per clock; its phase output must climb by the clock count
  task automatic t_nco;
    logic [15:0] p0;
    wr(2'h2, 8'h84, 20'h00001);
    wr(2'h2, 8'h86, 20'h00001);
    hop(0);
    tick(3);
    rd(2'h2, 8'h86, 20'h00001);
    p0 = nco_phase[47:32];
    tick(10);
    chk(24'(nco_phase[47:32]), 24'(16'(p0 + 16'h000A)));
  endtask : t_nco

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // Main sequence after a five-cycle reset
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    tick(2);
    t_regs();
    t_hop();
    t_sleep();
    t_stream();
    t_gain();
    t_portb();
    t_nco();
    finish_test();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
